/* include/dtc_pkg.sv */
// Purpose: shared constants and types of the dual timer/counter unit
// Assumes: 8-bit register port, 20 MHz system clock
// Notes: offsets are byte addresses on the register port

package dtc_pkg;

	// register offsets
	localparam logic [7:0] DTC_RUN_ADDR = 8'h88; // timer_run_flag_control
	localparam logic [7:0] DTC_MODE_ADDR = 8'h89; // timer_mode_control
	localparam logic [7:0] DTC_T0LO_ADDR = 8'h8a; // timer0_low_count
	localparam logic [7:0] DTC_T1LO_ADDR = 8'h8b; // timer1_low_count
	localparam logic [7:0] DTC_T0HI_ADDR = 8'h8c; // timer0_high_count
	localparam logic [7:0] DTC_T1HI_ADDR = 8'h8d; // timer1_high_count
	localparam logic [7:0] DTC_CLK_ADDR = 8'h8e; // clock_and_stretch_control
	localparam logic [7:0] DTC_ISTAT_ADDR = 8'hc0; // sticky event status, read only
	localparam logic [7:0] DTC_IEN_ADDR = 8'hc1; // event enable
	localparam logic [7:0] DTC_ICLR_ADDR = 8'hc2; // write one to clear, write only

	// timer_run_flag_control fields
	localparam int DTC_TF1_BIT = 7;
	localparam int DTC_TR1_BIT = 6;
	localparam int DTC_TF0_BIT = 5;
	localparam int DTC_TR0_BIT = 4;

	// timer_mode_control: one nibble per timer
	localparam int DTC_T0_NIB = 0;
	localparam int DTC_T1_NIB = 4;
	localparam int DTC_GATE_BIT = 3;
	localparam int DTC_CT_BIT = 2;
	localparam int DTC_MODE_LSB = 0;

	// clock_and_stretch_control fields
	localparam int DTC_T1M_BIT = 4;
	localparam int DTC_T0M_BIT = 3;

	// reset values
	localparam logic [7:0] DTC_RUN_RST = 8'h00;
	localparam logic [7:0] DTC_MODE_RST = 8'h00;
	localparam logic [7:0] DTC_CLK_RST = 8'h01;
	localparam logic [7:0] DTC_CNT_RST = 8'h00;
	localparam logic [1:0] DTC_IRQ_RST = 2'h0;

	// internal clock dividers
	localparam int DTC_DIV_FAST = 4;
	localparam int DTC_DIV_SLOW = 12;
	localparam logic [1:0] DTC_FAST_LAST = 2'(DTC_DIV_FAST - 1);
	localparam logic [3:0] DTC_SLOW_LAST = 4'(DTC_DIV_SLOW - 1);

	// mode select encodings
	typedef enum logic [1:0] {
		DTC_MODE_PRESCALE = 2'b00,
		DTC_MODE_WIDE = 2'b01,
		DTC_MODE_RELOAD = 2'b10,
		DTC_MODE_SPLIT = 2'b11
	} dtc_mode_e;

	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} dtc_bus_s;

	// result of one count step
	typedef struct packed {
		logic [7:0] lo;
		logic [7:0] hi;
		logic ovf;
	} dtc_step_s;

endpackage

/* rtl/dtc_timer_unit.sv */
// Purpose: two timer/counters with four modes, gating, count pins and interrupt
// Assumes: 20 MHz clk, bus strobes one cycle wide, isrAck pulses from the same clock
// Notes: register writes to count bytes win over counting in the same cycle

`timescale 1ns/100ps
`default_nettype none

module dtc_timer_unit (
	input wire logic clk,
	input wire logic rst_n,
	input wire dtc_pkg::dtc_bus_s bus,
	input wire logic [1:0] extIntPin,
	input wire logic [1:0] countPin,
	input wire logic [1:0] isrAck,
	output logic [7:0] rdata_r,
	output logic [1:0] overflowFlag_r,
	output logic irq_r
);
	import dtc_pkg::*;

	logic [7:0] runCtl_r;
	logic [7:0] modeCtl_r;
	logic [7:0] clkCtl_r;
	logic [7:0] t0Lo_r, t0Hi_r, t1Lo_r, t1Hi_r;
	logic [1:0] fastCnt_r;
	logic [3:0] slowCnt_r;
	logic [1:0] intMeta_r, intSync_r;
	logic [1:0] cntMeta_r, cntSync_r, cntPrev_r;
	logic [1:0] irqStat_r, irqEn_r;
	logic tick4, tick12, tick0, tick1;
	logic [1:0] fall;
	logic en0, en1, inc0, inc1, incH0;
	dtc_mode_e mode0, mode1;
	dtc_step_s step0, step1;
	logic ovf0, ovf1, ovfH0;
	logic [7:0] t0HiStep;
	logic wrRun, wrMode, wrClk, wrT0Lo, wrT0Hi, wrT1Lo, wrT1Hi, wrIEn, wrIClr;

	// pick the internal tick for one timer
	function automatic logic pickTick(input logic fast, input logic t4, input logic t12);
		pickTick = fast ? t4 : t12;
	endfunction

	// timer enable from run bit, gate bit and synchronised pin
	function automatic logic timerEnable(input logic run, input logic gate, input logic pin);
		timerEnable = run & (~gate | pin);
	endfunction

	// advance one timer by one count in the given mode
	function automatic dtc_step_s stepTimer(input dtc_mode_e m, input logic [7:0] lo,
			input logic [7:0] hi, input logic inc);
		dtc_step_s s;
		logic [5:0] pre;
		logic [16:0] wide;
		logic [8:0] hiSum;
		s.lo = lo;
		s.hi = hi;
		s.ovf = 1'b0;
		pre = {1'b0, lo[4:0]} + 6'h01;
		wide = {1'b0, hi, lo} + 17'h00001;
		hiSum = {1'b0, hi} + 9'h001;
		if (inc) begin
			unique case (m)
				DTC_MODE_PRESCALE: begin
					s.lo = {lo[7:5], pre[4:0]};
					if (pre[5]) begin
						s.hi = hiSum[7:0];
						s.ovf = hiSum[8];
					end
				end
				DTC_MODE_WIDE: begin
					s.lo = wide[7:0];
					s.hi = wide[15:8];
					s.ovf = wide[16];
				end
				DTC_MODE_RELOAD: begin
					s.ovf = (lo == 8'hff);
					s.lo = s.ovf ? hi : 8'(lo + 8'h01);
				end
				DTC_MODE_SPLIT: begin
					s.ovf = (lo == 8'hff);
					s.lo = 8'(lo + 8'h01);
				end
			endcase
		end
		return s;
	endfunction

	// register write decode
	assign wrRun = bus.wr && (bus.addr == DTC_RUN_ADDR);
	assign wrMode = bus.wr && (bus.addr == DTC_MODE_ADDR);
	assign wrClk = bus.wr && (bus.addr == DTC_CLK_ADDR);
	assign wrT0Lo = bus.wr && (bus.addr == DTC_T0LO_ADDR);
	assign wrT0Hi = bus.wr && (bus.addr == DTC_T0HI_ADDR);
	assign wrT1Lo = bus.wr && (bus.addr == DTC_T1LO_ADDR);
	assign wrT1Hi = bus.wr && (bus.addr == DTC_T1HI_ADDR);
	assign wrIEn = bus.wr && (bus.addr == DTC_IEN_ADDR);
	assign wrIClr = bus.wr && (bus.addr == DTC_ICLR_ADDR);

	// clk/4 and clk/12 enables, aligned since 12 is a multiple of 4
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fastCnt_r <= 2'h0;
			slowCnt_r <= 4'h0;
		end else begin
			fastCnt_r <= (fastCnt_r == DTC_FAST_LAST) ? 2'h0 : 2'(fastCnt_r + 2'h1);
			slowCnt_r <= (slowCnt_r == DTC_SLOW_LAST) ? 4'h0 : 4'(slowCnt_r + 4'h1);
		end
	end

	assign tick4 = (fastCnt_r == DTC_FAST_LAST);
	assign tick12 = (slowCnt_r == DTC_SLOW_LAST);
	assign tick1 = pickTick(clkCtl_r[DTC_T1M_BIT], tick4, tick12);
	assign tick0 = pickTick(clkCtl_r[DTC_T0M_BIT], tick4, tick12);

	// pin synchronisers and falling edge detect on the second stage only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			intMeta_r <= 2'h0;
			intSync_r <= 2'h0;
			cntMeta_r <= 2'h3;
			cntSync_r <= 2'h3;
			cntPrev_r <= 2'h3;
		end else begin
			intMeta_r <= extIntPin;
			intSync_r <= intMeta_r;
			cntMeta_r <= countPin;
			cntSync_r <= cntMeta_r;
			cntPrev_r <= cntSync_r;
		end
	end

	assign fall = cntPrev_r & ~cntSync_r;

	// count enables and count pulses
	assign mode0 = dtc_mode_e'(modeCtl_r[DTC_T0_NIB + DTC_MODE_LSB +: 2]);
	assign mode1 = dtc_mode_e'(modeCtl_r[DTC_T1_NIB + DTC_MODE_LSB +: 2]);
	assign en0 = timerEnable(runCtl_r[DTC_TR0_BIT], modeCtl_r[DTC_T0_NIB + DTC_GATE_BIT],
		intSync_r[0]);
	assign en1 = timerEnable(runCtl_r[DTC_TR1_BIT], modeCtl_r[DTC_T1_NIB + DTC_GATE_BIT],
		intSync_r[1]);
	assign inc0 = en0 & (modeCtl_r[DTC_T0_NIB + DTC_CT_BIT] ? fall[0] : tick0);
	assign inc1 = en1 & (mode1 != DTC_MODE_SPLIT)
		& (modeCtl_r[DTC_T1_NIB + DTC_CT_BIT] ? fall[1] : tick1);
	assign incH0 = (mode0 == DTC_MODE_SPLIT) & runCtl_r[DTC_TR1_BIT] & tick0;

	// next count values
	assign step0 = stepTimer(mode0, t0Lo_r, t0Hi_r, inc0);
	assign step1 = stepTimer(mode1, t1Lo_r, t1Hi_r, inc1);
	assign t0HiStep = incH0 ? 8'(t0Hi_r + 8'h01) : step0.hi;
	assign ovf0 = step0.ovf;
	assign ovfH0 = incH0 & (t0Hi_r == 8'hff);
	assign ovf1 = step1.ovf | ovfH0;

	// timer 0 count bytes, software write wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			t0Lo_r <= DTC_CNT_RST;
			t0Hi_r <= DTC_CNT_RST;
		end else begin
			t0Lo_r <= wrT0Lo ? bus.wdata : step0.lo;
			t0Hi_r <= wrT0Hi ? bus.wdata : t0HiStep;
		end
	end

	// timer 1 count bytes, software write wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			t1Lo_r <= DTC_CNT_RST;
			t1Hi_r <= DTC_CNT_RST;
		end else begin
			t1Lo_r <= wrT1Lo ? bus.wdata : step1.lo;
			t1Hi_r <= wrT1Hi ? bus.wdata : step1.hi;
		end
	end

	// mode and clock select registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			modeCtl_r <= DTC_MODE_RST;
			clkCtl_r <= DTC_CLK_RST;
		end else begin
			if (wrMode) begin
				modeCtl_r <= bus.wdata;
			end
			if (wrClk) begin
				clkCtl_r <= bus.wdata;
			end
		end
	end

	// run bits and overflow flags; hardware set beats software or service clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			runCtl_r <= DTC_RUN_RST;
		end else begin
			if (wrRun) begin
				runCtl_r[DTC_TR1_BIT] <= bus.wdata[DTC_TR1_BIT];
				runCtl_r[DTC_TR0_BIT] <= bus.wdata[DTC_TR0_BIT];
			end
			if (ovf0) begin
				runCtl_r[DTC_TF0_BIT] <= 1'b1;
			end else if (wrRun) begin
				runCtl_r[DTC_TF0_BIT] <= bus.wdata[DTC_TF0_BIT];
			end else if (isrAck[0]) begin
				runCtl_r[DTC_TF0_BIT] <= 1'b0;
			end
			if (ovf1) begin
				runCtl_r[DTC_TF1_BIT] <= 1'b1;
			end else if (wrRun) begin
				runCtl_r[DTC_TF1_BIT] <= bus.wdata[DTC_TF1_BIT];
			end else if (isrAck[1]) begin
				runCtl_r[DTC_TF1_BIT] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			overflowFlag_r <= 2'h0;
		end else begin
			overflowFlag_r <= {runCtl_r[DTC_TF1_BIT], runCtl_r[DTC_TF0_BIT]};
		end
	end

	// sticky event status, enable and interrupt line
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irqStat_r <= DTC_IRQ_RST;
			irqEn_r <= DTC_IRQ_RST;
			irq_r <= 1'b0;
		end else begin
			irqStat_r <= (irqStat_r & ~(wrIClr ? bus.wdata[1:0] : 2'h0)) | {ovf1, ovf0};
			if (wrIEn) begin
				irqEn_r <= bus.wdata[1:0];
			end
			irq_r <= |(irqStat_r & irqEn_r);
		end
	end

	// read data one cycle after the strobe, zero elsewhere
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 8'h00;
		end else if (bus.rd) begin
			unique case (bus.addr)
				DTC_RUN_ADDR: rdata_r <= {runCtl_r[7:4], 4'h0};
				DTC_MODE_ADDR: rdata_r <= modeCtl_r;
				DTC_T0LO_ADDR: rdata_r <= t0Lo_r;
				DTC_T1LO_ADDR: rdata_r <= t1Lo_r;
				DTC_T0HI_ADDR: rdata_r <= t0Hi_r;
				DTC_T1HI_ADDR: rdata_r <= t1Hi_r;
				DTC_CLK_ADDR: rdata_r <= clkCtl_r;
				DTC_ISTAT_ADDR: rdata_r <= {6'h00, irqStat_r};
				DTC_IEN_ADDR: rdata_r <= {6'h00, irqEn_r};
				default: rdata_r <= 8'h00;
			endcase
		end else begin
			rdata_r <= 8'h00;
		end
	end

	// checks
	gateHold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(modeCtl_r[DTC_T0_NIB + DTC_GATE_BIT] && !intSync_r[0] && !bus.wr)
		|=> $stable(t0Lo_r)) else $error("gated timer 0 advanced with pin low");

	runCount_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!modeCtl_r[DTC_T0_NIB + DTC_GATE_BIT] && runCtl_r[DTC_TR0_BIT] && tick0
		&& !modeCtl_r[DTC_T0_NIB + DTC_CT_BIT] && mode0 == DTC_MODE_WIDE && !bus.wr)
		|=> t0Lo_r == 8'($past(t0Lo_r) + 8'h01)) else $error("running timer 0 missed a tick");

	internalOnly_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!modeCtl_r[DTC_T0_NIB + DTC_CT_BIT] && !tick0 && !bus.wr)
		|=> $stable(t0Lo_r)) else $error("timer 0 moved without an internal tick");

	edgeCount_a: assert property (@(posedge clk) disable iff (!rst_n)
		(modeCtl_r[DTC_T0_NIB + DTC_CT_BIT] && en0 && mode0 == DTC_MODE_WIDE && !bus.wr)
		|=> t0Lo_r == 8'($past(t0Lo_r) + {7'h00, $past(fall[0])}))
		else $error("timer 0 edge count wrong");

	prescaleHold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(mode0 == DTC_MODE_PRESCALE && t0Lo_r[4:0] != 5'h1f && !bus.wr)
		|=> $stable(t0Hi_r)) else $error("high byte moved before prescaler wrap");

	wideCarry_a: assert property (@(posedge clk) disable iff (!rst_n)
		(mode0 == DTC_MODE_WIDE && inc0 && t0Lo_r == 8'hff && !bus.wr)
		|=> t0Hi_r == 8'($past(t0Hi_r) + 8'h01) && t0Lo_r == 8'h00)
		else $error("wide carry lost");

	autoReload_a: assert property (@(posedge clk) disable iff (!rst_n)
		(mode1 == DTC_MODE_RELOAD && inc1 && t1Lo_r == 8'hff && !bus.wr)
		|=> t1Lo_r == $past(t1Hi_r) && runCtl_r[DTC_TF1_BIT])
		else $error("reload or flag missing");

	splitHigh_a: assert property (@(posedge clk) disable iff (!rst_n)
		(mode0 == DTC_MODE_SPLIT && runCtl_r[DTC_TR1_BIT] && tick0 && !bus.wr)
		|=> t0Hi_r == 8'($past(t0Hi_r) + 8'h01)) else $error("split high byte stalled");

	splitHold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(mode1 == DTC_MODE_SPLIT && !bus.wr) |=> $stable(t1Lo_r) && $stable(t1Hi_r))
		else $error("timer 1 counted in split mode");

	slowDiv_a: assert property (@(posedge clk) disable iff (!rst_n)
		tick12 |=> !tick12 [*8] ##1 !tick12 ##1 !tick12 ##1 !tick12 ##1 tick12)
		else $error("slow divider period wrong");

	fastDiv_a: assert property (@(posedge clk) disable iff (!rst_n)
		tick4 |=> !tick4 [*3] ##1 tick4) else $error("fast divider period wrong");

	writeCount_a: assert property (@(posedge clk) disable iff (!rst_n)
		wrT1Hi |=> t1Hi_r == $past(bus.wdata)) else $error("count byte write lost");

	flagSet_a: assert property (@(posedge clk) disable iff (!rst_n)
		ovf1 |=> runCtl_r[DTC_TF1_BIT] ##1 overflowFlag_r[1])
		else $error("overflow flag not set");

	edgeOnce_a: assert property (@(posedge clk) disable iff (!rst_n)
		fall[0] |=> !fall[0]) else $error("one edge counted twice");

	splitFlag_a: assert property (@(posedge clk) disable iff (!rst_n)
		ovfH0 |=> runCtl_r[DTC_TF1_BIT]) else $error("split overflow missed flag");

	irqLine_a: assert property (@(posedge clk) disable iff (!rst_n)
		(|(irqStat_r & irqEn_r)) |=> irq_r) else $error("interrupt not raised");

	irqDrop_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!(|(irqStat_r & irqEn_r))) |=> !irq_r)
		else $error("interrupt held without cause");

	splitLow_a: assert property (@(posedge clk) disable iff (!rst_n)
		(mode0 == DTC_MODE_SPLIT && en0 && modeCtl_r[DTC_T0_NIB + DTC_CT_BIT] && fall[0]
		&& !bus.wr) |=> t0Lo_r == 8'($past(t0Lo_r) + 8'h01)) else $error("split low byte stalled");

	runOff_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!runCtl_r[DTC_TR0_BIT] && !bus.wr) |=> $stable(t0Lo_r))
		else $error("stopped timer 0 advanced");

	ackClear_a: assert property (@(posedge clk) disable iff (!rst_n)
		(isrAck[1] && !ovf1 && !wrRun) |=> !runCtl_r[DTC_TF1_BIT])
		else $error("service entry left flag set");

	stickyStat_a: assert property (@(posedge clk) disable iff (!rst_n)
		(irqStat_r[1] && !(wrIClr && bus.wdata[1])) |=> irqStat_r[1])
		else $error("status bit dropped without clear");

	readIdle_a: assert property (@(posedge clk) disable iff (!rst_n)
		!bus.rd |=> rdata_r == 8'h00)
		else $error("read data outside read cycle");

	writeLow_a: assert property (@(posedge clk) disable iff (!rst_n)
		wrT0Lo |=> t0Lo_r == $past(bus.wdata))
		else $error("low count byte write lost");

endmodule

`default_nettype wire

/* bench/dtc_pin_model.sv */
// Purpose: pin-side partner of the timer unit, drives count and gate pins
// Assumes: one clock, fall requests are one-cycle pulses spaced by the bench
// Notes: a fall holds the count pin low three cycles, then high again
`timescale 1ns/100ps
`default_nettype none

module dtc_pin_model (
	input wire logic clk,
	input wire logic [1:0] fallReq,
	input wire logic [1:0] gateLvl,
	output var logic [1:0] countPin,
	output var logic [1:0] extIntPin
);
	logic [1:0] lowCnt_r [2];

	// pins idle high for counting, low for gating
	initial begin
		countPin = 2'h3;
		extIntPin = 2'h0;
		lowCnt_r[0] = 2'h0;
		lowCnt_r[1] = 2'h0;
	end

	// each low phase outlasts two clocks so the synchroniser sees it
	always @(posedge clk) begin
		extIntPin <= gateLvl;
		for (int i = 0; i < 2; i++) begin
			if (fallReq[i]) begin
				lowCnt_r[i] <= 2'h3;
				countPin[i] <= 1'b0;
			end else if (lowCnt_r[i] != 2'h0) begin
				lowCnt_r[i] <= lowCnt_r[i] - 2'h1;
				countPin[i] <= (lowCnt_r[i] == 2'h1);
			end
		end
	end
endmodule

`default_nettype wire

/* bench/test_dtc_timer_unit.sv */
// Purpose: self-checking bench of the dual timer/counter unit
// Assumes: 20 MHz clock, register port with one-cycle strobes
// Notes: pin edges come from the partner model, expectations from constants
`timescale 1ns/100ps
`default_nettype none

module test_dtc_timer_unit;
	import dtc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	dtc_bus_s bus = '0;
	logic [1:0] isrAck = 2'h0;
	logic [1:0] fallReq = 2'h0;
	logic [1:0] gateLvl = 2'h0;
	logic [1:0] extIntPin;
	logic [1:0] countPin;
	logic [7:0] rdata_r;
	logic [1:0] overflowFlag_r;
	logic irq_r;
	logic [7:0] v;
	int errCount = 0;
	int cmpCount = 0;
	int cycles = 0;

	dtc_timer_unit dtc_timer_unit_inst (.clk(clk), .rst_n(rst_n), .bus(bus),
		.extIntPin(extIntPin), .countPin(countPin), .isrAck(isrAck),
		.rdata_r(rdata_r), .overflowFlag_r(overflowFlag_r), .irq_r(irq_r));
	dtc_pin_model dtc_pin_model_inst (.clk(clk), .fallReq(fallReq), .gateLvl(gateLvl),
		.countPin(countPin), .extIntPin(extIntPin));

	// 50 ns clock
	initial begin
		forever #25 clk = ~clk;
	end

	// verdict and end of run
	task automatic finalReport();
		if (errCount == 0 && cmpCount > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmpCount++;
		if (got !== exp) begin
			errCount++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// count window check, edges of the window may land either way
	task automatic rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
		cmpCount++;
		if ($isunknown(got) || got < lo || got > hi) begin
			errCount++;
			$display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 d = rdata_r;
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk(d, e);
	endtask

	// one falling edge on a count pin, then time for it to land
	task automatic pulse(input int i);
		@(posedge clk);
		fallReq[i] <= 1'b1;
		@(posedge clk);
		fallReq[i] <= 1'b0;
		repeat (8) @(posedge clk);
	endtask

	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles > 20000) begin
			errCount++;
			finalReport();
		end
	end

	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rc(DTC_RUN_ADDR, DTC_RUN_RST);
		rc(DTC_MODE_ADDR, DTC_MODE_RST);
		rc(DTC_CLK_ADDR, DTC_CLK_RST);
		for (int a = 0; a < 4; a++) begin
			rc(DTC_T0LO_ADDR + 8'(a), DTC_CNT_RST);
		end
		rc(8'h90, 8'h00);
		rc(DTC_ICLR_ADDR, 8'h00);
		wr(DTC_T1HI_ADDR, 8'ha5);
		rc(DTC_T1HI_ADDR, 8'ha5);
		// internal clock rate per timer and select bit
		for (int t = 0; t < 2; t++) begin
			for (int f = 0; f < 2; f++) begin
				wr(DTC_MODE_ADDR, t ? 8'h10 : 8'h01);
				wr(DTC_CLK_ADDR, f ? (t ? 8'h10 : 8'h08) : 8'h00);
				wr(t ? DTC_T1LO_ADDR : DTC_T0LO_ADDR, 8'h00);
				wr(DTC_RUN_ADDR, t ? 8'h40 : 8'h10);
				repeat (46) @(posedge clk);
				wr(DTC_RUN_ADDR, 8'h00);
				rd(t ? DTC_T1LO_ADDR : DTC_T0LO_ADDR, v);
				rng(v, f ? 8'h0b : 8'h03, f ? 8'h0d : 8'h05);
			end
		end
		// pin counting in the wide mode, carry into the high byte
		wr(DTC_MODE_ADDR, 8'h05);
		wr(DTC_T0LO_ADDR, 8'hff);
		wr(DTC_T0HI_ADDR, 8'h12);
		wr(DTC_RUN_ADDR, 8'h10);
		pulse(0);
		rc(DTC_T0LO_ADDR, 8'h00);
		rc(DTC_T0HI_ADDR, 8'h13);
		// gate qualifier low blocks, high lets through
		wr(DTC_MODE_ADDR, 8'h0d);
		pulse(0);
		rc(DTC_T0LO_ADDR, 8'h00);
		gateLvl <= 2'h1;
		repeat (4) @(posedge clk);
		pulse(0);
		rc(DTC_T0LO_ADDR, 8'h01);
		// prescaler carry into the high byte
		wr(DTC_MODE_ADDR, 8'h04);
		wr(DTC_T0LO_ADDR, 8'h1f);
		wr(DTC_T0HI_ADDR, 8'h05);
		pulse(0);
		rc(DTC_T0LO_ADDR, 8'h00);
		rc(DTC_T0HI_ADDR, 8'h06);
		// auto-reload, overflow flag, status and interrupt
		wr(DTC_MODE_ADDR, 8'h60);
		wr(DTC_T1HI_ADDR, 8'h80);
		wr(DTC_T1LO_ADDR, 8'hff);
		wr(DTC_RUN_ADDR, 8'h40);
		pulse(1);
		rc(DTC_T1LO_ADDR, 8'h80);
		rc(DTC_T1HI_ADDR, 8'h80);
		rc(DTC_RUN_ADDR, 8'hc0);
		rc(DTC_ISTAT_ADDR, 8'h02);
		chk({7'h00, irq_r}, 8'h00);
		wr(DTC_IEN_ADDR, 8'h02);
		repeat (2) @(posedge clk);
		#1 chk({7'h00, irq_r}, 8'h01);
		wr(DTC_ICLR_ADDR, 8'h02);
		repeat (2) @(posedge clk);
		#1 chk({7'h00, irq_r}, 8'h00);
		rc(DTC_ISTAT_ADDR, 8'h00);
		@(posedge clk);
		isrAck <= 2'h2;
		@(posedge clk);
		isrAck <= 2'h0;
		rc(DTC_RUN_ADDR, 8'h40);
		wr(DTC_RUN_ADDR, 8'h60);
		rc(DTC_RUN_ADDR, 8'h60);
		chk({6'h00, overflowFlag_r}, 8'h01);
		// service entry of timer 0 clears its flag too
		@(posedge clk);
		isrAck <= 2'h1;
		@(posedge clk);
		isrAck <= 2'h0;
		rc(DTC_RUN_ADDR, 8'h40);
		chk({6'h00, overflowFlag_r}, 8'h00);
		// split mode: timer 1 holds, high byte of timer 0 runs under run bit 1
		wr(DTC_CLK_ADDR, 8'h18);
		wr(DTC_MODE_ADDR, 8'h37);
		wr(DTC_T0LO_ADDR, 8'h00);
		wr(DTC_T0HI_ADDR, 8'hfe);
		wr(DTC_T1LO_ADDR, 8'h33);
		wr(DTC_RUN_ADDR, 8'h50);
		pulse(0);
		repeat (40) @(posedge clk);
		rc(DTC_T0LO_ADDR, 8'h01);
		rc(DTC_T1LO_ADDR, 8'h33);
		rc(DTC_RUN_ADDR, 8'hd0);
		rc(DTC_ISTAT_ADDR, 8'h02);
		wr(DTC_RUN_ADDR, 8'h10);
		wr(DTC_T0HI_ADDR, 8'h40);
		repeat (20) @(posedge clk);
		rc(DTC_T0HI_ADDR, 8'h40);
		finalReport();
	end
endmodule

`default_nettype wire
